// ### common/iodma_pkg.sv
package iodma_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0C;
    localparam logic [7:0] OFS_AUX_OUT = 8'h10;
    localparam logic [7:0] OFS_AUX_CHAN = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h20;
    // control fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_ABORT_BIT = 1;
    localparam int CTRL_CLR_FIFO_BIT = 2;
    localparam int CTRL_STOP_BIT = 3;
    localparam int CTRL_CHAIN_BIT = 4;
    // status fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_SAMPLING_BIT = 1;
    localparam int ST_OVERRUN_BIT = 2;
    // interrupt fields
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_OVR_BIT = 1;
    localparam int IRQ_W = 2;
    // single-channel aux write fields
    localparam int AUXCH_IDX_LSB = 0;
    localparam int AUXCH_VAL_BIT = 4;
    localparam int AUX_W = 4;
    // reset values
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [AUX_W-1:0] AUX_RST = 4'h0;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    // transfer geometry
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_RST = 24'h00_0000;
    localparam logic [CNT_W-1:0] MAX_BLOCK_BYTES = 24'h80_0000;
    localparam logic [CNT_W-1:0] BYTES_PER_WORD = 24'h00_0004;
    localparam logic [31:0] WORD_ADDR_MASK = 32'hFFFF_FFFC;
    localparam logic [31:0] DESC_ADDR_MASK = 32'hFFFF_FFF0;
    localparam logic [1:0] DESC_LAST_IDX = 2'h2;
    localparam int DESC_END_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DESC = 2'b01,
        ST_REQ = 2'b11,
        ST_WRITE = 2'b10
    } iodma_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } iodma_wr_t;
endpackage

// ### rtl/iodma_top.sv
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
// Contract
// RULE1: four independently writable auxiliary output bits.
// RULE2: software picks aux channel by index 0 to 3 only.
// RULE3: channel write sets chosen bit to 0 or 1, others kept.
// RULE4: host loads count and 32-bit start address before start.
// RULE5: count held in bytes, up to 2^23 bytes per block; descriptor counts are loaded uncapped, up to 2^24-1.
// RULE6: each memory write carries one full 32-bit word.
// RULE7: sampled words go into FIFO, drained while bus held.
// RULE8: FIFO empty mid-block releases bus, re-requests on new data.
// RULE9: count exhausted ends block, shows done, raises enabled interrupt.
// RULE10: transfer runs until last word moved or software aborts.
// RULE11: descriptor addresses are 16-byte aligned, buffers fetched from them.
// RULE12: in chained mode block count is ignored.
// RULE13: contiguous start address is word aligned.
// RULE14: clear option empties FIFO at start, else queued words kept.
// RULE15: stop option halts sampling at completion, else sampling continues.
// RULE16: status reads 1 while in progress, 0 when done.
// RULE17: input word arriving with FIFO full sets sticky overrun.
// RULE18: reset leaves engine idle, FIFO empty, overrun clear, aux zero.
module iodma_top #(
    parameter int FIFO_DEPTH = 16,
    parameter int PTR_W = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // sampled input pins
    input wire logic [31:0] di_word,
    input wire logic di_strobe,
    // host bus master
    output logic bus_req,
    input wire logic bus_gnt,
    output logic wr_valid,
    output iodma_pkg::iodma_wr_t wr_req,
    input wire logic wr_ready,
    output logic rd_valid,
    output logic [31:0] rd_addr,
    input wire logic rd_ready,
    input wire logic rd_rsp_valid,
    input wire logic [31:0] rd_rsp_data,
    // auxiliary outputs and interrupt
    output logic [iodma_pkg::AUX_W-1:0] aux_out,
    output logic irq
);
    import iodma_pkg::*;

    function automatic logic [31:0] apply_strb(input logic [31:0] old,
        input logic [31:0] val, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = val[i*8 +: 8];
        end
        return r;
    endfunction

    // pin synchronisers, strobe edge taken from stages two and three
    logic [31:0] di_s1_ff, di_s2_ff;
    logic [2:0] stb_sync_ff;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            di_s1_ff <= 32'h0000_0000;
            di_s2_ff <= 32'h0000_0000;
            stb_sync_ff <= 3'h0;
        end
        else
        begin
            di_s1_ff <= di_word;
            di_s2_ff <= di_s1_ff;
            stb_sync_ff <= {stb_sync_ff[1:0], di_strobe};
        end
    end
    logic sample_evt;
    assign sample_evt = stb_sync_ff[1] & ~stb_sync_ff[2];

    // register and bus slave state
    logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [4:0] ctrl_ff;
    logic [31:0] addr_reg_ff;
    logic [CNT_W-1:0] count_reg_ff;
    logic [AUX_W-1:0] aux_ff;
    logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff;
    logic nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
    logic [7:0] nxt_awaddr;
    logic [31:0] nxt_wdata, nxt_rdata, wmerge;
    logic [3:0] nxt_wstrb;
    logic [1:0] nxt_bresp, nxt_rresp;
    logic [4:0] nxt_ctrl;
    logic [31:0] nxt_addr_reg;
    logic [CNT_W-1:0] nxt_count_reg;
    logic [AUX_W-1:0] nxt_aux;
    logic [IRQ_W-1:0] nxt_irq_stat, nxt_irq_en, irq_set;
    logic do_write, start_cmd, abort_cmd, done_evt, ovr_evt;
    logic busy_ff, sampling_ff;

    assign s_awready = !aw_got_ff && !bvalid_ff;
    assign s_wready = !w_got_ff && !bvalid_ff;
    assign s_arready = !rvalid_ff;
    assign s_bvalid = bvalid_ff;
    assign s_bresp = bresp_ff;
    assign s_rvalid = rvalid_ff;
    assign s_rdata = rdata_ff;
    assign s_rresp = rresp_ff;
    assign aux_out = aux_ff;
    assign irq = |(irq_stat_ff & irq_en_ff);
    assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wmerge = apply_strb(32'h0000_0000, wdata_ff, wstrb_ff);
    assign start_cmd = do_write && awaddr_ff == OFS_CTRL
        && wmerge[CTRL_START_BIT];
    assign abort_cmd = do_write && awaddr_ff == OFS_CTRL
        && wmerge[CTRL_ABORT_BIT];
    assign irq_set = {ovr_evt, done_evt};

    // byte-lane merge of the addressed register with the written word
    logic [31:0] old_word, new_word;
    always_comb
    begin
        case (awaddr_ff)
            OFS_CTRL: old_word = {27'h0, ctrl_ff};
            OFS_COUNT: old_word = {8'h00, count_reg_ff};
            OFS_AUX_OUT: old_word = {28'h0, aux_ff};
            OFS_IRQ_EN: old_word = {30'h0, irq_en_ff};
            default: old_word = addr_reg_ff;
        endcase
    end
    assign new_word = apply_strb(old_word, wdata_ff, wstrb_ff);

    always_comb
    begin
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        nxt_ctrl = ctrl_ff;
        nxt_addr_reg = addr_reg_ff;
        nxt_count_reg = count_reg_ff;
        nxt_aux = aux_ff;
        nxt_irq_en = irq_en_ff;
        nxt_irq_stat = irq_stat_ff;
        if (s_awvalid && s_awready)
        begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = s_awaddr;
        end
        if (s_wvalid && s_wready)
        begin
            nxt_w_got = 1'b1;
            nxt_wdata = s_wdata;
            nxt_wstrb = s_wstrb;
        end
        if (do_write)
        begin
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            case (awaddr_ff)
                OFS_CTRL: nxt_ctrl = new_word[4:0];
                OFS_ADDR: nxt_addr_reg = new_word;
                // RULE5: byte count capped
                OFS_COUNT:
                begin
                    nxt_count_reg = new_word[CNT_W-1:0];
                    if (new_word > {8'h00, MAX_BLOCK_BYTES})
                        nxt_count_reg = MAX_BLOCK_BYTES;
                end
                // RULE1: whole port write
                OFS_AUX_OUT: nxt_aux = new_word[AUX_W-1:0];
                // RULE3: one bit, others kept
                OFS_AUX_CHAN:
                begin
                    if (wstrb_ff[0])
                        nxt_aux[wdata_ff[AUXCH_IDX_LSB +: 2]] =
                            wdata_ff[AUXCH_VAL_BIT];
                end
                OFS_IRQ_CLR: nxt_irq_stat = irq_stat_ff
                    & ~wmerge[IRQ_W-1:0];
                OFS_IRQ_EN: nxt_irq_en = new_word[IRQ_W-1:0];
                OFS_STATUS, OFS_IRQ_STAT: nxt_bresp = RESP_OKAY;
                default: nxt_bresp = RESP_DECERR;
            endcase
            // start and abort are commands, never stored
            nxt_ctrl[CTRL_START_BIT] = 1'b0;
            nxt_ctrl[CTRL_ABORT_BIT] = 1'b0;
        end
        // set wins over a clear in the same cycle
        nxt_irq_stat = nxt_irq_stat | irq_set;
        if (s_bvalid && s_bready)
            nxt_bvalid = 1'b0;
        if (s_rvalid && s_rready)
            nxt_rvalid = 1'b0;
        if (s_arvalid && s_arready)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            case (s_araddr)
                OFS_CTRL: nxt_rdata = {27'h0, ctrl_ff};
                // RULE16: 1 while in progress, 0 when done
                OFS_STATUS: nxt_rdata = {29'h0,
                    irq_stat_ff[IRQ_OVR_BIT], sampling_ff, busy_ff};
                OFS_ADDR: nxt_rdata = addr_reg_ff;
                OFS_COUNT: nxt_rdata = {8'h00, count_reg_ff};
                OFS_AUX_OUT: nxt_rdata = {28'h0, aux_ff};
                OFS_IRQ_STAT: nxt_rdata = {30'h0, irq_stat_ff};
                OFS_IRQ_EN: nxt_rdata = {30'h0, irq_en_ff};
                OFS_AUX_CHAN, OFS_IRQ_CLR: nxt_rdata = 32'h0000_0000;
                default: nxt_rresp = RESP_DECERR;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        // RULE18: aux zero, overrun clear
        if (!aresetn)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
            ctrl_ff <= CTRL_RST;
            addr_reg_ff <= ADDR_RST;
            count_reg_ff <= CNT_RST;
            aux_ff <= AUX_RST;
            irq_en_ff <= IRQ_RST;
            irq_stat_ff <= IRQ_RST;
        end
        else
        begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            ctrl_ff <= nxt_ctrl;
            addr_reg_ff <= nxt_addr_reg;
            count_reg_ff <= nxt_count_reg;
            aux_ff <= nxt_aux;
            irq_en_ff <= nxt_irq_en;
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    // input fifo in flip-flops
    logic [31:0] fifo_mem_ff [FIFO_DEPTH];
    logic [PTR_W-1:0] wptr_ff, rptr_ff, nxt_wptr, nxt_rptr;
    logic [PTR_W:0] fill_ff, nxt_fill;
    logic fifo_empty, fifo_full, push, pop, fifo_clr;
    assign fifo_empty = fill_ff == '0;
    assign fifo_full = fill_ff == (PTR_W+1)'(FIFO_DEPTH);
    // RULE7: each sample queued while sampling and fifo not full, except one arriving in the cycle of a start flush
    assign push = sample_evt && sampling_ff && !fifo_full;
    // RULE17: arrival while full
    assign ovr_evt = sample_evt && sampling_ff && fifo_full;
    assign pop = wr_valid && wr_ready;
    // RULE14: optional flush at start
    // option bits come with the start write itself
    assign fifo_clr = start_cmd && !busy_ff && new_word[CTRL_CLR_FIFO_BIT];

    always_comb
    begin
        nxt_wptr = wptr_ff;
        nxt_rptr = rptr_ff;
        nxt_fill = fill_ff;
        if (fifo_clr)
        begin
            nxt_wptr = '0;
            nxt_rptr = '0;
            nxt_fill = '0;
        end
        else
        begin
            if (push)
                nxt_wptr = wptr_ff + 1'b1;
            if (pop)
                nxt_rptr = rptr_ff + 1'b1;
            nxt_fill = fill_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            fill_ff <= '0;
        end
        else
        begin
            wptr_ff <= nxt_wptr;
            rptr_ff <= nxt_rptr;
            fill_ff <= nxt_fill;
        end
        if (push)
            fifo_mem_ff[wptr_ff] <= di_s2_ff;
    end

    // transfer engine
    iodma_state_t state_ff, nxt_state;
    logic [31:0] cur_addr_ff, nxt_cur_addr, desc_ptr_ff, nxt_desc_ptr;
    logic [31:0] next_desc_ff, nxt_next_desc;
    logic [CNT_W-1:0] remain_ff, nxt_remain;
    logic [1:0] desc_idx_ff, nxt_desc_idx;
    logic rd_pend_ff, nxt_rd_pend, last_ff, nxt_last;
    logic nxt_busy, nxt_sampling, chain_ff, nxt_chain, block_end;

    assign wr_req.addr = cur_addr_ff;
    assign wr_req.data = fifo_mem_ff[rptr_ff];
    assign rd_addr = desc_ptr_ff + {28'h0, desc_idx_ff, 2'b00};
    assign rd_valid = state_ff == ST_DESC && bus_gnt && !rd_pend_ff;
    // RULE6: one full word per write
    assign wr_valid = state_ff == ST_WRITE && bus_gnt && !fifo_empty
        && !block_end;
    // RULE8: no request in ST_REQ while nothing queued
    assign bus_req = state_ff == ST_DESC || state_ff == ST_WRITE
        || (state_ff == ST_REQ && !fifo_empty);
    assign block_end = remain_ff < BYTES_PER_WORD;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cur_addr = cur_addr_ff;
        nxt_desc_ptr = desc_ptr_ff;
        nxt_next_desc = next_desc_ff;
        nxt_remain = remain_ff;
        nxt_desc_idx = desc_idx_ff;
        nxt_rd_pend = rd_pend_ff;
        nxt_last = last_ff;
        nxt_busy = busy_ff;
        nxt_sampling = sampling_ff;
        nxt_chain = chain_ff;
        done_evt = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                // RULE4: start uses preloaded address, and preloaded count only when not chained
                if (start_cmd)
                begin
                    nxt_busy = 1'b1;
                    nxt_sampling = 1'b1;
                    nxt_chain = new_word[CTRL_CHAIN_BIT];
                    // RULE11: descriptor chain from aligned pointer
                    // RULE12: chained count comes from descriptors
                    if (new_word[CTRL_CHAIN_BIT])
                    begin
                        nxt_state = ST_DESC;
                        nxt_desc_ptr = addr_reg_ff & DESC_ADDR_MASK;
                        nxt_desc_idx = 2'h0;
                    end
                    else
                    begin
                        // RULE13: low address bits dropped
                        nxt_state = ST_REQ;
                        nxt_cur_addr = addr_reg_ff & WORD_ADDR_MASK;
                        nxt_remain = count_reg_ff;
                        nxt_last = 1'b1;
                    end
                end
            end
            ST_DESC:
            begin
                if (rd_valid && rd_ready)
                    nxt_rd_pend = 1'b1;
                if (rd_pend_ff && rd_rsp_valid)
                begin
                    nxt_rd_pend = 1'b0;
                    nxt_desc_idx = desc_idx_ff + 2'h1;
                    case (desc_idx_ff)
                        2'h0: nxt_cur_addr = rd_rsp_data & WORD_ADDR_MASK;
                        2'h1: nxt_remain = rd_rsp_data[CNT_W-1:0];
                        default:
                        begin
                            nxt_next_desc = rd_rsp_data & DESC_ADDR_MASK;
                            nxt_last = rd_rsp_data[DESC_END_BIT];
                        end
                    endcase
                    if (desc_idx_ff == DESC_LAST_IDX)
                        nxt_state = ST_REQ;
                end
            end
            ST_REQ:
            begin
                if (block_end)
                    nxt_state = ST_WRITE;
                else if (bus_gnt && !fifo_empty)
                    nxt_state = ST_WRITE;
            end
            default:
            begin
                if (pop)
                begin
                    nxt_cur_addr = cur_addr_ff + 32'h0000_0004;
                    nxt_remain = remain_ff - BYTES_PER_WORD;
                end
                // RULE8: release bus when starved
                else if (!block_end && (fifo_empty || !bus_gnt))
                    nxt_state = ST_REQ;
                // RULE9: byte count exhausted
                if (block_end)
                begin
                    if (chain_ff && !last_ff)
                    begin
                        nxt_state = ST_DESC;
                        nxt_desc_ptr = next_desc_ff;
                        nxt_desc_idx = 2'h0;
                    end
                    else
                    begin
                        nxt_state = ST_IDLE;
                        nxt_busy = 1'b0;
                        done_evt = 1'b1;
                        // RULE15: optional sampling stop
                        if (ctrl_ff[CTRL_STOP_BIT])
                            nxt_sampling = 1'b0;
                    end
                end
            end
        endcase
        // RULE10: abort ends the transfer early
        if (abort_cmd)
        begin
            nxt_state = ST_IDLE;
            nxt_busy = 1'b0;
            nxt_rd_pend = 1'b0;
            done_evt = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        // RULE18: idle after reset
        if (!aresetn)
        begin
            state_ff <= ST_IDLE;
            cur_addr_ff <= ADDR_RST;
            desc_ptr_ff <= ADDR_RST;
            next_desc_ff <= ADDR_RST;
            remain_ff <= CNT_RST;
            desc_idx_ff <= 2'h0;
            rd_pend_ff <= 1'b0;
            last_ff <= 1'b0;
            busy_ff <= 1'b0;
            sampling_ff <= 1'b0;
            chain_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cur_addr_ff <= nxt_cur_addr;
            desc_ptr_ff <= nxt_desc_ptr;
            next_desc_ff <= nxt_next_desc;
            remain_ff <= nxt_remain;
            desc_idx_ff <= nxt_desc_idx;
            rd_pend_ff <= nxt_rd_pend;
            last_ff <= nxt_last;
            busy_ff <= nxt_busy;
            sampling_ff <= nxt_sampling;
            chain_ff <= nxt_chain;
        end
    end

    default clocking chk_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence seq_final_write;
        wr_valid && wr_ready && remain_ff == BYTES_PER_WORD;
    endsequence

    chk_aux_single_bit: assert property ( // RULE3
        do_write && awaddr_ff == OFS_AUX_CHAN && wstrb_ff[0] |=>
        aux_out[$past(wdata_ff[1:0])] == $past(wdata_ff[AUXCH_VAL_BIT])
        && $countones(aux_out ^ $past(aux_out)) <= 1)
        else $error("aux channel write disturbed other bits");
    chk_count_cap: assert property ( // RULE5
        count_reg_ff <= MAX_BLOCK_BYTES)
        else $error("byte count above block limit");
    chk_word_step: assert property ( // RULE6
        wr_valid && wr_ready |=> cur_addr_ff == $past(cur_addr_ff) + 32'h4)
        else $error("write address did not advance one word");
    chk_release_bus: assert property ( // RULE8
        state_ff == ST_REQ && fifo_empty |-> !bus_req && busy_ff)
        else $error("bus held or block ended while starved");
    chk_done_irq: assert property ( // RULE9
        seq_final_write ##1 (!chain_ff && !abort_cmd) |=> !busy_ff
        && irq_stat_ff[IRQ_DONE_BIT] && (irq || !irq_en_ff[IRQ_DONE_BIT]))
        else $error("completion not reported");
    chk_abort_idle: assert property ( // RULE10
        abort_cmd |=> state_ff == ST_IDLE && !busy_ff && !wr_valid)
        else $error("abort did not stop the engine");
    chk_fifo_flush: assert property ( // RULE14
        fifo_clr |=> fill_ff == '0)
        else $error("fifo not emptied at start");
    chk_stop_sample: assert property ( // RULE15
        done_evt && ctrl_ff[CTRL_STOP_BIT] |=> !sampling_ff [*2])
        else $error("sampling continued after completion");
    chk_overrun_sticky: assert property ( // RULE17
        sample_evt && sampling_ff && fifo_full
        |=> irq_stat_ff[IRQ_OVR_BIT] && fill_ff == $past(fill_ff)
        - (PTR_W+1)'($past(pop)))
        else $error("overrun not flagged");
    chk_desc_align: assert property ( // RULE11
        rd_valid |-> rd_addr[3:0] == {desc_idx_ff, 2'b00})
        else $error("descriptor read misaligned");
endmodule // iodma_top

// ### verification/iodma_host_model.sv
`timescale 1ns/10ps
module iodma_host_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // host bus
    input wire logic bus_req,
    output logic bus_gnt,
    output logic wr_ready,
    input wire logic rd_valid,
    input wire logic [31:0] rd_addr,
    output logic rd_ready,
    output logic rd_rsp_valid,
    output logic [31:0] rd_rsp_data
);
    always_ff @(posedge aclk)
    begin
        bus_gnt <= aresetn && bus_req && ($urandom % 5 != 0);
        wr_ready <= aresetn && ($urandom % 3 != 0);
        rd_ready <= aresetn;
        rd_rsp_valid <= aresetn && rd_valid && rd_ready;
        rd_rsp_data <= !aresetn ? 32'h0 : (rd_valid && rd_ready) ?
            (rd_addr[3] ? 32'h11 : rd_addr[2] ? 32'h8 : 32'h2000) :
            ~rd_rsp_data;
    end
endmodule // iodma_host_model

// ### verification/iodma_top_test.sv
`timescale 1ns/10ps
module iodma_top_test;
    import iodma_pkg::*;
    logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0;
    logic s_arvalid = 0, s_rready = 0, di_strobe = 0, irq, bus_req, bus_gnt;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, wr_valid;
    logic wr_ready, rd_valid, rd_ready, rd_rsp_valid;
    logic [7:0] s_awaddr = 0, s_araddr = 0;
    logic [31:0] s_wdata = 0, di_word = 0, s_rdata, rd_addr, rd_rsp_data;
    logic [1:0] s_bresp, s_rresp;
    logic [3:0] aux_out, aux_exp = 0;
    logic [63:0] exp_q[$];
    iodma_wr_t wr_req;
    int error_cnt = 0, check_count = 0;
    always #50 aclk = ~aclk;
    iodma_top iodma_top_i (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready, .di_word, .di_strobe, .bus_req, .bus_gnt,
        .wr_valid, .wr_req, .wr_ready, .rd_valid, .rd_addr, .rd_ready,
        .rd_rsp_valid, .rd_rsp_data, .aux_out, .irq);
    iodma_host_model iodma_host_model_i (.aclk, .aresetn, .bus_req, .bus_gnt,
        .wr_ready, .rd_valid, .rd_addr, .rd_ready, .rd_rsp_valid, .rd_rsp_data);
    task chk(input string n, input logic [63:0] e, input logic [63:0] s);
        check_count++;
        if (s !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            error_cnt++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bit b;
        b = 0;
        @(posedge aclk);
        s_awaddr <= a; s_wdata <= d; s_awvalid <= 1; s_wvalid <= 1;
        s_bready <= 1;
        while (!b)
        begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 0;
            if (s_wready) s_wvalid <= 0;
            b = s_bvalid;
        end
        s_bready <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        bit b;
        b = 0;
        @(posedge aclk);
        s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
        while (!b)
        begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 0;
            b = s_rvalid;
        end
        s_rready <= 0;
        chk("read data", {32'h0, e}, {32'h0, s_rdata});
        chk("read resp", {62'h0, r}, {62'h0, s_rresp});
    endtask
    // each sample is one strobe rise held 3 cycles, then a 9-cycle gap before the next
    task put(input logic [31:0] w, input logic [31:0] a);
        @(posedge aclk);
        di_word <= w; di_strobe <= 1;
        // address 0: word must stay queued, be flushed or be dropped on overrun, never written
        if (a != 0) exp_q.push_back({a, w});
        repeat (3) @(posedge aclk);
        di_strobe <= 0;
        repeat (8) @(posedge aclk);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge aclk)
        if (wr_valid && wr_ready)
            chk("mem write", exp_q.size() ? exp_q.pop_front() : 64'h0, wr_req);
    initial
    begin
        repeat (3000) @(posedge aclk);
        error_cnt++;
        complete_run;
    end
    initial
    begin
        logic v;
        void'($urandom(11244));
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        rd(OFS_STATUS, 32'h0, RESP_OKAY);
        rd(OFS_AUX_OUT, 32'h0, RESP_OKAY);
        for (int i = 0; i < 4; i++)
        begin
            v = $urandom % 2;
            aux_exp[i] = v;
            wr(OFS_AUX_CHAN, {27'h0, v, 2'h0, 2'(i)});
            rd(OFS_AUX_OUT, {28'h0, aux_exp}, RESP_OKAY);
        end
        rd(8'h40, 32'h0, RESP_DECERR);
        wr(OFS_IRQ_EN, 32'h1);
        wr(OFS_ADDR, 32'h1000);
        wr(OFS_COUNT, 32'h10);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_STATUS, 32'h3, RESP_OKAY);
        wr(OFS_CTRL, 32'h2);
        rd(OFS_STATUS, 32'h2, RESP_OKAY);
        put($urandom, 0);
        wr(OFS_CTRL, 32'hD);
        rd(OFS_STATUS, 32'h3, RESP_OKAY);
        for (int i = 0; i < 4; i++) put($urandom, 32'h1000 + 4 * i);
        repeat (20) @(posedge aclk);
        chk("irq", 64'h1, {63'h0, irq});
        rd(OFS_STATUS, 32'h0, RESP_OKAY);
        wr(OFS_IRQ_CLR, 32'h1);
        rd(OFS_IRQ_STAT, 32'h0, RESP_OKAY);
        wr(OFS_COUNT, 32'h0);
        wr(OFS_ADDR, 32'h100);
        wr(OFS_CTRL, 32'h11);
        for (int i = 0; i < 2; i++) put($urandom, 32'h2000 + 4 * i);
        repeat (20) @(posedge aclk);
        rd(OFS_STATUS, 32'h2, RESP_OKAY);
        rd(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
        repeat (17) put($urandom, 0);
        rd(OFS_STATUS, 32'h6, RESP_OKAY);
        chk("queue left", 64'h0, 64'(exp_q.size()));
        complete_run;
    end
endmodule // iodma_top_test
